//--- design/cba_column_burst_map.svh
`ifndef CBA_COLUMN_BURST_MAP_SVH
`define CBA_COLUMN_BURST_MAP_SVH

// command pin codes {row strobe, column strobe, write enable}, active low
`define CBA_CMD_NOP 3'h7
`define CBA_CMD_READ 3'h5
`define CBA_CMD_WRITE 3'h4

// mode_reg bits 2..0 burst_len codes and the burst type bit position
`define CBA_BL4 3'h2
`define CBA_BL8 3'h3
`define CBA_BURST_TYPE_BIT 3

// page and segment geometry
`define CBA_PAGE_COLS 1024
`define CBA_SEGS_BL4 256
`define CBA_SEGS_BL8 128

// beat pairs per burst (two beats per device clock)
`define CBA_PAIRS_BL4 3'h2
`define CBA_PAIRS_BL8 3'h4

// address line carrying the auto-precharge flag
`define CBA_AP_BIT 10

// col_to_col_delay in clocks, least column_latency, read launch lead
`define CBA_CCD_CLK 2'h2
`define CBA_CL_MIN 3'h3
`define CBA_RD_LEAD 4'h2

// reset values
`define CBA_RST_GAP 2'h3

`endif

//--- design/cba_pkg.sv
package cba_pkg;

    typedef enum logic [2:0] {
        CBA_DESEL,
        CBA_NOP,
        CBA_READ,
        CBA_WRITE,
        CBA_OTHER
    } cba_cmd_t;

    typedef enum logic [0:0] {
        CBA_RD_IDLE,
        CBA_RD_BURST
    } cba_rd_state_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cba_pins_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] bank;
        logic [9:0] col;
        logic ap;
    } cba_col_cmd_t;

    typedef struct packed {
        logic [2:0] bank;
        logic [9:0] col;
        logic [2:0] pairs;
        logic bl8;
        logic ilv;
    } cba_wdesc_t;

    typedef struct packed {
        logic [9:0] second;
        logic [9:0] first;
    } cba_col_pair_t;

endpackage

//--- design/cba_column_burst.sv
`timescale 1ns/1ps
`default_nettype none
`include "cba_column_burst_map.svh"

module cba_column_burst
    import cba_pkg::*;
#(
    parameter int LAT_MAX = 16,
    parameter int DQ_W = 16,
    parameter int WBUF_AW = 3
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cke_i,
    input wire cba_pins_t cmd_i,
    input wire logic [2:0] bank_select_i,
    input wire logic [13:0] addr_i,
    input wire logic [2:0] column_latency_i,
    input wire logic [2:0] additive_latency_i,
    input wire logic [2:0] burst_len_i,
    input wire logic burst_ilv_i,
    input wire logic dqs_clk_i,
    input wire logic [2*DQ_W-1:0] dq_i,
    output logic [2*DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic dqs_o,
    output logic dqs_oe_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [2:0] mem_bank_o,
    output cba_col_pair_t mem_col_o,
    output logic [2*DQ_W-1:0] mem_wdata_o,
    input wire logic [2*DQ_W-1:0] mem_rdata_i,
    output cba_col_cmd_t exec_o,
    output logic [3:0] read_latency_o,
    output logic [3:0] write_latency_o,
    output logic cfg_err_o
);

    // every register of the device clock domain
    typedef struct packed {
        cba_col_cmd_t [LAT_MAX-1:0] pipe;
        logic [1:0] wr_gap;
        cba_rd_state_t rd_state;
        cba_col_cmd_t rd_cmd;
        logic rd_bl8;
        logic rd_ilv;
        logic [1:0] rd_idx;
        cba_wdesc_t [1:0] wq;
        logic [1:0] wq_cnt;
        logic wq_head;
        logic [1:0] wr_idx;
        logic [WBUF_AW:0] rptr;
        logic [WBUF_AW:0] wg_meta;
        logic [WBUF_AW:0] wg_sync;
        logic mem_rd;
        logic mem_wr;
        logic [2:0] mem_bank;
        cba_col_pair_t mem_col;
        logic [2*DQ_W-1:0] mem_wdata;
        logic [2*DQ_W-1:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        cba_col_cmd_t exec;
        logic [3:0] rl;
        logic [3:0] wl;
        logic cfg_err;
    } cba_core_t;

    // registers clocked by the controller's write strobe
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [WBUF_AW:0] wbin;
        logic [WBUF_AW:0] wgray;
    } cba_link_t;

    cba_core_t core_q;
    cba_core_t core_d;
    cba_link_t link_q;
    cba_link_t link_d;
    // write pairs held until the core drains them
    logic [2*DQ_W-1:0] wbuf [0:(1<<WBUF_AW)-1];

    // clock enable low is treated like a deselect
    function automatic cba_cmd_t cmd_decode(input logic cke, input cba_pins_t p);
        if (!cke || p.cs_n) begin
            return CBA_DESEL;
        end
        case ({p.ras_n, p.cas_n, p.we_n})
            `CBA_CMD_NOP: return CBA_NOP;
            `CBA_CMD_READ: return CBA_READ;
            `CBA_CMD_WRITE: return CBA_WRITE;
            default: return CBA_OTHER;
        endcase
    endfunction

    // column of beat n; four-beat bursts never leave their segment
    function automatic logic [9:0] beat_col(input logic [9:0] start, input logic [2:0] n,
                                            input logic bl8, input logic ilv);
        logic [2:0] low;
        low = start[2:0] ^ n;
        if (!ilv) begin
            low[1:0] = start[1:0] + n[1:0];
            low[2] = start[2] ^ n[2];
        end
        if (!bl8) begin
            low[2] = start[2];
        end
        return {start[9:3], low};
    endfunction

    // write pointer crosses gray coded, one bit per step
    function automatic logic [WBUF_AW:0] gray2bin(input logic [WBUF_AW:0] g);
        logic [WBUF_AW:0] b;
        b = '0;
        b[WBUF_AW] = g[WBUF_AW];
        for (int i = WBUF_AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // link domain: write beats captured on controller strobe
    always_comb begin
        link_d = link_q;
        // strobe runs only in bursts, so reset needs strobe edges here
        link_d.rst_sync = {link_q.rst_sync[0], rst_i};
        if (link_q.rst_sync[1]) begin
            link_d.wbin = '0;
            link_d.wgray = '0;
        end else begin
            link_d.wbin = link_q.wbin + 1'b1;
            link_d.wgray = link_d.wbin ^ (link_d.wbin >> 1);
        end
    end

    always_ff @(posedge dqs_clk_i) begin
        link_q <= link_d;
    end

    always_ff @(posedge dqs_clk_i) begin
        if (!link_q.rst_sync[1]) begin
            wbuf[link_q.wbin[WBUF_AW-1:0]] <= dq_i;
        end
    end

    // core domain
    always_comb begin
        cba_cmd_t kind;
        cba_col_cmd_t incoming;
        cba_col_cmd_t launch;
        cba_wdesc_t desc;
        logic bl8;
        logic cfg_bad;
        logic [3:0] rl;
        logic [2:0] pairs;
        logic [2:0] beat;
        logic [WBUF_AW:0] wbin;
        logic [1:0] cnt;
        logic head;
        kind = CBA_DESEL;
        incoming = '0;
        launch = '0;
        desc = '0;
        bl8 = 1'b0;
        cfg_bad = 1'b0;
        rl = '0;
        pairs = '0;
        beat = '0;
        wbin = '0;
        cnt = '0;
        head = 1'b0;
        core_d = core_q;

        // configuration checked every cycle; commands refused while bad
        bl8 = (burst_len_i == `CBA_BL8);
        rl = {1'b0, additive_latency_i} + {1'b0, column_latency_i};
        cfg_bad = ((burst_len_i != `CBA_BL4) && !bl8) || (column_latency_i < `CBA_CL_MIN);
        core_d.rl = rl;
        core_d.wl = rl - 4'h1;
        core_d.cfg_err = cfg_bad;

        // bank and start column taken with the command
        kind = cmd_decode(cke_i, cmd_i);
        incoming.valid = ((kind == CBA_READ) || (kind == CBA_WRITE)) && !cfg_bad;
        incoming.write = (kind == CBA_WRITE);
        incoming.bank = bank_select_i;
        incoming.col = addr_i[9:0];
        incoming.ap = addr_i[`CBA_AP_BIT];

        // posted column commands age through the pipe
        // entry k holds the command taken k+1 edges ago
        core_d.pipe = {core_q.pipe[LAT_MAX-2:0], incoming};
        if (additive_latency_i == 3'h0) begin
            core_d.exec = incoming;
        end else begin
            core_d.exec = core_q.pipe[additive_latency_i - 3'h1];
        end

        // read engine: first pair fetched so data lands at read_latency
        // a new launch replaces the burst in flight
        launch = core_q.pipe[rl - `CBA_RD_LEAD];
        core_d.mem_rd = 1'b0;
        core_d.mem_wr = 1'b0;
        if (launch.valid && !launch.write) begin
            core_d.rd_cmd = launch;
            core_d.rd_bl8 = bl8;
            core_d.rd_ilv = burst_ilv_i;
            core_d.rd_idx = 2'h1;
            core_d.rd_state = CBA_RD_BURST;
            core_d.mem_rd = 1'b1;
            core_d.mem_bank = launch.bank;
            core_d.mem_col.first = beat_col(launch.col, 3'h0, bl8, burst_ilv_i);
            core_d.mem_col.second = beat_col(launch.col, 3'h1, bl8, burst_ilv_i);
        end else begin
            case (core_q.rd_state)
                CBA_RD_IDLE: begin
                    core_d.rd_idx = 2'h0;
                end
                CBA_RD_BURST: begin
                    pairs = core_q.rd_bl8 ? `CBA_PAIRS_BL8 : `CBA_PAIRS_BL4;
                    beat = {core_q.rd_idx, 1'b0};
                    core_d.mem_rd = 1'b1;
                    core_d.mem_bank = core_q.rd_cmd.bank;
                    core_d.mem_col.first = beat_col(core_q.rd_cmd.col, beat, core_q.rd_bl8, core_q.rd_ilv);
                    core_d.mem_col.second = beat_col(core_q.rd_cmd.col, beat | 3'h1, core_q.rd_bl8,
                                                     core_q.rd_ilv);
                    if ({1'b0, core_q.rd_idx} + 3'h1 == pairs) begin
                        core_d.rd_state = CBA_RD_IDLE;
                        core_d.rd_idx = 2'h0;
                    end else begin
                        core_d.rd_idx = core_q.rd_idx + 2'h1;
                    end
                end
                default: begin
                    core_d.rd_state = CBA_RD_IDLE;
                end
            endcase
        end

        // preamble cycle then one beat pair per clock
        core_d.dq = core_q.mem_rd ? mem_rdata_i : '0;
        core_d.dq_oe = core_q.mem_rd;
        core_d.dqs = core_q.mem_rd;
        core_d.dqs_oe = core_d.mem_rd | core_q.mem_rd;

        // write drain: pairs crossing from the link side
        core_d.wg_meta = link_q.wgray;
        core_d.wg_sync = core_q.wg_meta;
        wbin = gray2bin(core_q.wg_sync);
        cnt = core_q.wq_cnt;
        head = core_q.wq_head;
        // reads own the array port; a write pair waits until a cycle with no read fetch
        if ((core_q.rptr != wbin) && !core_d.mem_rd) begin
            core_d.rptr = core_q.rptr + 1'b1;
            // a pair with no pending descriptor is dropped
            if (cnt != 2'h0) begin
                desc = core_q.wq[head];
                beat = {core_q.wr_idx, 1'b0};
                core_d.mem_wr = 1'b1;
                core_d.mem_bank = desc.bank;
                core_d.mem_col.first = beat_col(desc.col, beat, desc.bl8, desc.ilv);
                core_d.mem_col.second = beat_col(desc.col, beat | 3'h1, desc.bl8, desc.ilv);
                core_d.mem_wdata = wbuf[core_q.rptr[WBUF_AW-1:0]];
                if ({1'b0, core_q.wr_idx} + 3'h1 == desc.pairs) begin
                    core_d.wr_idx = 2'h0;
                    head = ~head;
                    cnt = cnt - 2'h1;
                end else begin
                    core_d.wr_idx = core_q.wr_idx + 2'h1;
                end
            end
        end

        // write descriptors queued at acceptance
        if (incoming.valid && incoming.write) begin
            // write two clocks after an eight-beat write cuts it to two pairs
            if ((core_q.wr_gap == `CBA_CCD_CLK - 2'h1) && bl8 && (cnt != 2'h0)) begin
                core_d.wq[head ^ cnt[1]].pairs = `CBA_PAIRS_BL4;
            end
            if (cnt != 2'h2) begin
                core_d.wq[head ^ cnt[0]].bank = incoming.bank;
                core_d.wq[head ^ cnt[0]].col = incoming.col;
                core_d.wq[head ^ cnt[0]].pairs = bl8 ? `CBA_PAIRS_BL8 : `CBA_PAIRS_BL4;
                core_d.wq[head ^ cnt[0]].bl8 = bl8;
                core_d.wq[head ^ cnt[0]].ilv = burst_ilv_i;
                cnt = cnt + 2'h1;
            end
            core_d.wr_gap = 2'h0;
        end else if (core_q.wr_gap != `CBA_RST_GAP) begin
            core_d.wr_gap = core_q.wr_gap + 2'h1;
        end
        core_d.wq_cnt = cnt;
        core_d.wq_head = head;
    end

    // gap counter leaves reset as if long idle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            core_q <= '0;
            core_q.wr_gap <= `CBA_RST_GAP;
        end else begin
            core_q <= core_d;
        end
    end

    assign dq_o = core_q.dq;
    assign dq_oe_o = core_q.dq_oe;
    assign dqs_o = core_q.dqs;
    assign dqs_oe_o = core_q.dqs_oe;
    assign mem_rd_o = core_q.mem_rd;
    assign mem_wr_o = core_q.mem_wr;
    assign mem_bank_o = core_q.mem_bank;
    assign mem_col_o = core_q.mem_col;
    assign mem_wdata_o = core_q.mem_wdata;
    assign exec_o = core_q.exec;
    assign read_latency_o = core_q.rl;
    assign write_latency_o = core_q.wl;
    assign cfg_err_o = core_q.cfg_err;

endmodule // cba_column_burst

`default_nettype wire

//--- test/cba_props.sv
`timescale 1ns/1ps
`default_nettype none
module cba_props
    import cba_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cke_i,
    input wire cba_pins_t cmd_i,
    input wire logic [13:0] addr_i,
    input wire logic [2:0] bank_select_i,
    input wire logic [2:0] column_latency_i,
    input wire logic [2:0] additive_latency_i,
    input wire logic [2:0] burst_len_i,
    input wire cba_col_cmd_t exec_o,
    input wire logic [3:0] read_latency_o,
    input wire logic [3:0] write_latency_o,
    input wire logic cfg_err_o,
    input wire logic dq_oe_o,
    input wire logic dqs_o,
    input wire logic dqs_oe_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic sel, rdc, wrc, al0;
    assign sel = cke_i && !cmd_i.cs_n;
    assign rdc = sel && cmd_i[2:0] == 3'h5;
    assign wrc = sel && cmd_i[2:0] == 3'h4;
    assign al0 = additive_latency_i == 3'h0;
    a_nop_ignored: assert property (exec_o.valid && al0 |-> $past(rdc || wrc))
        else $error("exec without column command");
    a_read_now: assert property (rdc && al0 && !cfg_err_o |=> exec_o.valid && !exec_o.write
        && exec_o.col == $past(addr_i[9:0]) && exec_o.bank == $past(bank_select_i))
        else $error("read not issued");
    a_write_now: assert property (wrc && al0 && !cfg_err_o |=> exec_o.valid && exec_o.write
        && exec_o.ap == $past(addr_i[10]))
        else $error("write not issued");
    a_posted_read: assert property (rdc && additive_latency_i == 3'h2 && !cfg_err_o
        |-> ##3 exec_o.valid && exec_o.col == $past(addr_i[9:0], 3))
        else $error("posted read wrong");
    a_rl_sum: assert property ($stable(additive_latency_i) && $stable(column_latency_i)
        |=> read_latency_o == 4'($past(additive_latency_i)) + 4'($past(column_latency_i)))
        else $error("read latency wrong");
    a_wl_minus: assert property (read_latency_o != 4'h0 |-> write_latency_o == read_latency_o - 4'h1)
        else $error("write latency wrong");
    a_bad_burst: assert property (!(burst_len_i inside {3'h2, 3'h3}) |=> cfg_err_o)
        else $error("bad burst code accepted");
    a_err_block: assert property ((rdc || wrc) && cfg_err_o && al0 |=> !exec_o.valid)
        else $error("command taken in error");
    a_strobe_data: assert property (dq_oe_o |-> dqs_oe_o && dqs_o)
        else $error("data without strobe");
    a_preamble: assert property ($rose(dqs_oe_o) |-> !dqs_o && !dq_oe_o ##1 dq_oe_o)
        else $error("no read preamble");
endmodule // cba_props
`default_nettype wire

//--- test/cba_strobe_model.sv
`timescale 1ns/1ps
`default_nettype none
module cba_strobe_model (
    output logic strobe_o,
    output logic [31:0] data_o
);
    initial begin
        strobe_o = 1'b0;
        data_o = '0;
    end
    // one pair per rising edge, strobe idle low between bursts
    task automatic send(input int n);
        for (int j = 0; j < n; j++) begin
            data_o = {16'hA001 + 16'(2 * j), 16'hA000 + 16'(2 * j)};
            #8 strobe_o = 1'b1;
            #8 data_o = ~data_o;
            #8 strobe_o = 1'b0;
            #8;
        end
    endtask
endmodule // cba_strobe_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_top
    import cba_pkg::*;
;
    logic clock_i = 1'b0, rst_i, cke_i, burst_ilv_i, dqs_clk_i;
    cba_pins_t cmd_i;
    logic [2:0] bank_select_i, column_latency_i, additive_latency_i, burst_len_i;
    logic [13:0] addr_i;
    logic [31:0] dq_i, dq_o, mem_wdata_o, mem_rdata_i;
    logic dq_oe_o, dqs_o, dqs_oe_o, mem_rd_o, mem_wr_o, cfg_err_o;
    logic [2:0] mem_bank_o;
    cba_col_pair_t mem_col_o;
    cba_col_cmd_t exec_o;
    logic [3:0] read_latency_o, write_latency_o;
    int failures = 0, samples_checked = 0;
    always #25 clock_i = ~clock_i;
    assign mem_rdata_i = {6'h00, mem_col_o.second, 6'h00, mem_col_o.first};
    cba_column_burst i_cba_column_burst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .cke_i(cke_i),
        .cmd_i(cmd_i),
        .bank_select_i(bank_select_i),
        .addr_i(addr_i),
        .column_latency_i(column_latency_i),
        .additive_latency_i(additive_latency_i),
        .burst_len_i(burst_len_i),
        .burst_ilv_i(burst_ilv_i),
        .dqs_clk_i(dqs_clk_i),
        .dq_i(dq_i),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o),
        .dqs_o(dqs_o),
        .dqs_oe_o(dqs_oe_o),
        .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o),
        .mem_bank_o(mem_bank_o),
        .mem_col_o(mem_col_o),
        .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i),
        .exec_o(exec_o),
        .read_latency_o(read_latency_o),
        .write_latency_o(write_latency_o),
        .cfg_err_o(cfg_err_o)
    );
    cba_strobe_model i_cba_strobe_model (.strobe_o(dqs_clk_i), .data_o(dq_i));
    task automatic complete_run;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [9:0] bcol(input logic [9:0] s, input int k);
        return {s[9:3], burst_ilv_i ? s[2:0] ^ 3'(k) : {s[2] ^ k[2], s[1:0] + 2'(k)}};
    endfunction
    function automatic logic [19:0] pcols(input logic [9:0] c0, c1, input logic two, input int j);
        logic [9:0] s;
        int b;
        s = (two && j >= 2) ? c1 : c0;
        b = (two && j >= 2) ? 2 * j - 4 : 2 * j;
        return {bcol(s, b + 1), bcol(s, b)};
    endfunction
    task automatic put(input logic w, input logic [9:0] c);
        cmd_i = {1'b0, 3'h5 - 3'(w)};
        addr_i = {3'h0, c[0], c};
    endtask
    task automatic issue(input logic w, input logic [9:0] c0, c1, input logic two);
        put(w, c0);
        @(negedge clock_i);
        cmd_i = 4'h7;
        @(negedge clock_i);
        if (two)
            put(w, c1);
        @(negedge clock_i);
        cmd_i = 4'h7;
    endtask
    task automatic quiet;
        int t;
        t = 0;
        repeat (15) begin
            @(negedge clock_i);
            if (dq_oe_o !== 1'b0 || mem_wr_o !== 1'b0)
                t++;
        end
        `CHK(t, 0)
    endtask
    task automatic xfer(input logic w, input logic [9:0] c0, c1, input logic two);
        int n, t;
        logic [19:0] pc;
        n = (burst_len_i == 3'h3) ? 4 : 2;
        n = two ? n + 2 : n;
        issue(w, c0, c1, two);
        if (w) begin
            repeat (additive_latency_i + column_latency_i - 3) @(negedge clock_i);
            fork
                i_cba_strobe_model.send(n);
                for (int j = 0; j < n; j++) begin
                    t = 0;
                    do @(negedge clock_i); while (mem_wr_o !== 1'b1 && t++ < 40);
                    `CHK(mem_col_o, pcols(c0, c1, two, j))
                    `CHK(mem_wdata_o, {16'hA001 + 16'(2 * j), 16'hA000 + 16'(2 * j)})
                    `CHK(mem_bank_o, bank_select_i)
                end
            join
            quiet();
        end else begin
            t = 2;
            while (dq_oe_o !== 1'b1 && t < 40) begin
                @(negedge clock_i);
                t++;
            end
            `CHK(t, additive_latency_i + column_latency_i)
            for (int j = 0; j < n; j++) begin
                pc = pcols(c0, c1, two, j);
                `CHK(dq_o, {6'h00, pc[19:10], 6'h00, pc[9:0]})
                `CHK(mem_rd_o, j < n - 1)
                `CHK(dqs_o, 1'b1)
                @(negedge clock_i);
            end
            `CHK(dq_oe_o, 1'b0)
        end
    endtask
    initial begin
        #1_000_000;
        failures++;
        complete_run();
    end
    initial begin
        rst_i = 1'b1;
        cke_i = 1'b1;
        cmd_i = 4'h7;
        bank_select_i = 3'h5;
        addr_i = '0;
        additive_latency_i = 3'h0;
        column_latency_i = 3'h3;
        burst_len_i = 3'h2;
        burst_ilv_i = 1'b0;
        i_cba_strobe_model.send(4);
        @(negedge clock_i);
        `CHK(dq_oe_o, 1'b0)
        rst_i = 1'b0;
        // two idle strobe edges carry the reset release to the link side
        i_cba_strobe_model.send(2);
        repeat (2) @(negedge clock_i);
        `CHK(read_latency_o, 4'h3)
        `CHK(write_latency_o, 4'h2)
        for (int m = 0; m < 16; m++) begin
            burst_len_i = m[0] ? 3'h3 : 3'h2;
            burst_ilv_i = m[1];
            repeat (2) @(negedge clock_i);
            xfer(m[3], 10'h3F9 + 10'(m), 10'h106 ^ 10'(m), m[2]);
        end
        additive_latency_i = 3'h2;
        column_latency_i = 3'h4;
        repeat (3) @(negedge clock_i);
        `CHK(read_latency_o, 4'h6)
        `CHK(write_latency_o, 4'h5)
        xfer(1'b0, 10'h2A5, 10'h013, 1'b1);
        xfer(1'b1, 10'h2A6, 10'h013, 1'b1);
        cmd_i = 4'hD;
        @(negedge clock_i);
        cmd_i = 4'h5;
        cke_i = 1'b0;
        @(negedge clock_i);
        cmd_i = 4'h7;
        cke_i = 1'b1;
        quiet();
        burst_len_i = 3'h1;
        additive_latency_i = 3'h0;
        repeat (2) @(negedge clock_i);
        `CHK(cfg_err_o, 1'b1)
        issue(1'b0, 10'h000, 10'h000, 1'b0);
        quiet();
        complete_run();
    end
endmodule // tb_top
bind cba_column_burst cba_props i_cba_props (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .cke_i(cke_i),
    .cmd_i(cmd_i),
    .addr_i(addr_i),
    .bank_select_i(bank_select_i),
    .column_latency_i(column_latency_i),
    .additive_latency_i(additive_latency_i),
    .burst_len_i(burst_len_i),
    .exec_o(exec_o),
    .read_latency_o(read_latency_o),
    .write_latency_o(write_latency_o),
    .cfg_err_o(cfg_err_o),
    .dq_oe_o(dq_oe_o),
    .dqs_o(dqs_o),
    .dqs_oe_o(dqs_oe_o)
);
`default_nettype wire
